// File: core/hfw_pkg.sv
package hfw_pkg;

  // ==========================================================
  // Channel layout: index 0 is channel 2, index 1 is channel 3
  localparam int CH_NUM = 2;

  // ==========================================================
  // Register byte offsets
  localparam logic [CH_NUM-1:0][7:0] UNDER_ADDR = {8'h40, 8'h30};
  localparam logic [CH_NUM-1:0][7:0] OVER_ADDR  = {8'h41, 8'h31};
  localparam logic [CH_NUM-1:0][7:0] DEB_ADDR   = {8'h44, 8'h34};
  localparam logic [CH_NUM-1:0][7:0] ROUTE_ADDR = {8'h45, 8'h35};

  // ==========================================================
  // Field positions and reset values
  localparam int OVER_DEB_LSB    = 4;
  localparam int UNDER_DEB_LSB   = 0;
  localparam int ROUTE_OVER_BIT  = 4;
  localparam int ROUTE_UNDER_BIT = 3;
  localparam logic [7:0] LIMIT_RESET = 8'h00;
  localparam logic [3:0] CODE_RESET  = 4'h0;
  localparam logic [7:0] READ_ZERO   = 8'h00;

  // ==========================================================
  // Limit scaling, in millivolts
  localparam int MV_W = 13;
  localparam logic [MV_W-1:0] UNITY_BASE_MV = 13'h00c8;
  localparam logic [MV_W-1:0] UNITY_STEP_MV = 13'h0005;
  localparam logic [MV_W-1:0] QUAD_BASE_MV  = 13'h0320;
  localparam logic [MV_W-1:0] QUAD_STEP_MV  = 13'h0014;

  // Range multiplier selection
  typedef enum logic {HFW_SCALE_UNITY, HFW_SCALE_QUAD} hfw_scale_type;

  // ==========================================================
  // Debounce timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int DEB_BASE_NS   = 100;
  localparam int DEB_SAT_CODE  = 10;
  localparam int DEB_CNT_W     = 12;

  // Cycles for a debounce code, least time rounded up
  function automatic logic [DEB_CNT_W-1:0] deb_cycles(input logic [3:0] code);
    int sh;
    int t_ns;
    sh   = (int'(code) > DEB_SAT_CODE) ? DEB_SAT_CODE : int'(code);
    t_ns = DEB_BASE_NS << sh;
    return DEB_CNT_W'((t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  endfunction

endpackage

// File: core/hfw_debounce.sv
module hfw_debounce (
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  input  wire logic       raw_i,
  input  wire logic [3:0] code_i,
  output logic            filt_o
);

  // ==========================================================
  // State
  typedef struct packed {
    logic                           filt;
    logic [hfw_pkg::DEB_CNT_W-1:0]  cnt;
  } hfw_deb_state_type;

  hfw_deb_state_type s_reg;
  hfw_deb_state_type s_next;
  logic [hfw_pkg::DEB_CNT_W-1:0] target;

  // Follow input only after it differs for the whole interval
  always_comb begin
    target = hfw_pkg::deb_cycles(code_i);
    s_next = s_reg;
    if (raw_i == s_reg.filt) begin
      s_next.cnt = '0; // RULE_06
    end else if (s_reg.cnt + 1'b1 >= target) begin
      s_next.filt = raw_i; // RULE_06
      s_next.cnt  = '0;
    end else begin
      s_next.cnt = s_reg.cnt + 1'b1;
    end
    if (rst_i) begin
      s_next = '0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    s_reg <= s_next;
  end

  assign filt_o = s_reg.filt;

endmodule // hfw_debounce

// File: core/hfw_limit_scale.sv
module hfw_limit_scale (
  input  wire logic                      sys_clk_i,
  input  wire logic                      rst_i,
  input  wire logic [7:0]                code_i,
  input  wire hfw_pkg::hfw_scale_type    scale_i,
  output logic [hfw_pkg::MV_W-1:0]       mv_o
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [hfw_pkg::MV_W-1:0] mv;
  } hfw_scale_state_type;

  hfw_scale_state_type s_reg;
  hfw_scale_state_type s_next;

  // Code to millivolts per range setting
  always_comb begin
    s_next = s_reg;
    if (scale_i == hfw_pkg::HFW_SCALE_QUAD) begin // RULE_03
      s_next.mv = hfw_pkg::QUAD_BASE_MV
                + hfw_pkg::MV_W'(code_i) * hfw_pkg::QUAD_STEP_MV; // RULE_05
    end else begin
      s_next.mv = hfw_pkg::UNITY_BASE_MV
                + hfw_pkg::MV_W'(code_i) * hfw_pkg::UNITY_STEP_MV; // RULE_04
    end
    if (rst_i) begin
      s_next = '0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    s_reg <= s_next;
  end

  assign mv_o = s_reg.mv;

endmodule // hfw_limit_scale

// File: core/hfw_window_cfg.sv
// Contract
// RULE_01 - Each channel has a read-write 8-bit overvoltage limit in bits 7:0 of its register.
// RULE_02 - Each channel has a read-write 8-bit undervoltage limit in bits 7:0 of its register.
// RULE_03 - Limit codes are read per the range multiplier, unity or fourfold.
// RULE_04 - Unity scaling maps code 0 to 0.2 V plus 5 mV per step up to 1.475 V.
// RULE_05 - Fourfold scaling maps code 0 to 0.8 V plus 20 mV per step up to 5.9 V.
// RULE_06 - A fault is raised only after the comparator is stable for the full debounce time.
// RULE_07 - Filter bits 7:4 set overvoltage debounce, 0.1 us doubling, 1010b up at 102.4 us.
// RULE_08 - Filter bits 3:0 set undervoltage debounce with the same encoding.
// RULE_09 - Routing bit 4 set sends the overvoltage fault to the reset output.
// RULE_10 - Routing bit 3 set sends the undervoltage fault to the reset output.
// RULE_11 - Routing reserved bits read zero, and reset request is the OR of routed faults.
module hfw_window_cfg (
  input  wire logic                                       sys_clk_i,
  input  wire logic                                       rst_i,
  // Register access port
  input  wire logic [7:0]                                 reg_addr_i,
  input  wire logic [7:0]                                 reg_wdata_i,
  input  wire logic                                       reg_wr_i,
  input  wire logic                                       reg_rd_i,
  output logic [7:0]                                      reg_rdata_o,
  output logic                                            reg_rvalid_o,
  // Range multiplier from the scaling register
  input  wire hfw_pkg::hfw_scale_type                     range_multiplier_setting_i,
  // Raw comparator outputs, index 0 channel 2
  input  wire logic [hfw_pkg::CH_NUM-1:0]                 over_cmp_i,
  input  wire logic [hfw_pkg::CH_NUM-1:0]                 under_cmp_i,
  // Scaled limits for the comparators
  output logic [hfw_pkg::CH_NUM-1:0][hfw_pkg::MV_W-1:0]   over_limit_mv_o,
  output logic [hfw_pkg::CH_NUM-1:0][hfw_pkg::MV_W-1:0]   under_limit_mv_o,
  // Debounced faults and reset request
  output logic [hfw_pkg::CH_NUM-1:0]                      fast_path_over_fault_o,
  output logic [hfw_pkg::CH_NUM-1:0]                      fast_path_under_fault_o,
  output logic                                            reset_output_o
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [hfw_pkg::CH_NUM-1:0][7:0] fast_over_limit;
    logic [hfw_pkg::CH_NUM-1:0][7:0] fast_under_limit;
    logic [hfw_pkg::CH_NUM-1:0][3:0] over_debounce_code;
    logic [hfw_pkg::CH_NUM-1:0][3:0] under_debounce_code;
    logic [hfw_pkg::CH_NUM-1:0]      route_over_fault_to_reset;
    logic [hfw_pkg::CH_NUM-1:0]      route_under_fault_to_reset;
    logic [7:0]                      rdata;
    logic                            rvalid;
    logic                            reset_req;
  } hfw_main_state_type;

  hfw_main_state_type s_reg;
  hfw_main_state_type s_next;

  logic [hfw_pkg::CH_NUM-1:0] over_flt;
  logic [hfw_pkg::CH_NUM-1:0] under_flt;

  // ==========================================================
  // Read decode

  // Debounce config register image
  function automatic logic [7:0] deb_image(input logic [3:0] ov, input logic [3:0] uv);
    logic [7:0] v;
    v = hfw_pkg::READ_ZERO;
    v[hfw_pkg::OVER_DEB_LSB +: 4]  = ov;
    v[hfw_pkg::UNDER_DEB_LSB +: 4] = uv;
    return v;
  endfunction

  // Fault routing register image, reserved bits zero
  function automatic logic [7:0] route_image(input logic ov, input logic uv);
    logic [7:0] v;
    v = hfw_pkg::READ_ZERO;
    v[hfw_pkg::ROUTE_OVER_BIT]  = ov;
    v[hfw_pkg::ROUTE_UNDER_BIT] = uv;
    return v;
  endfunction

  // Register read mux, unmapped reads zero
  function automatic logic [7:0] read_reg(input hfw_main_state_type st,
                                          input logic [7:0] addr);
    logic [7:0] v;
    v = hfw_pkg::READ_ZERO;
    for (int ch = 0; ch < hfw_pkg::CH_NUM; ch++) begin
      if (addr == hfw_pkg::OVER_ADDR[ch]) begin
        v = st.fast_over_limit[ch]; // RULE_01
      end
      if (addr == hfw_pkg::UNDER_ADDR[ch]) begin
        v = st.fast_under_limit[ch]; // RULE_02
      end
      if (addr == hfw_pkg::DEB_ADDR[ch]) begin
        v = deb_image(st.over_debounce_code[ch], st.under_debounce_code[ch]);
      end
      if (addr == hfw_pkg::ROUTE_ADDR[ch]) begin
        v = route_image(st.route_over_fault_to_reset[ch],
                        st.route_under_fault_to_reset[ch]); // RULE_11
      end
    end
    return v;
  endfunction

  // ==========================================================
  // Next state
  always_comb begin
    s_next        = s_reg;
    s_next.rvalid = reg_rd_i;
    s_next.rdata  = reg_rd_i ? read_reg(s_reg, reg_addr_i) : hfw_pkg::READ_ZERO;

    // Register writes, unmapped addresses ignored
    for (int ch = 0; ch < hfw_pkg::CH_NUM; ch++) begin
      if (reg_wr_i) begin
        if (reg_addr_i == hfw_pkg::OVER_ADDR[ch]) begin
          s_next.fast_over_limit[ch] = reg_wdata_i; // RULE_01
        end
        if (reg_addr_i == hfw_pkg::UNDER_ADDR[ch]) begin
          s_next.fast_under_limit[ch] = reg_wdata_i; // RULE_02
        end
        if (reg_addr_i == hfw_pkg::DEB_ADDR[ch]) begin
          s_next.over_debounce_code[ch]  = reg_wdata_i[hfw_pkg::OVER_DEB_LSB +: 4]; // RULE_07
          s_next.under_debounce_code[ch] = reg_wdata_i[hfw_pkg::UNDER_DEB_LSB +: 4]; // RULE_08
        end
        if (reg_addr_i == hfw_pkg::ROUTE_ADDR[ch]) begin
          s_next.route_over_fault_to_reset[ch]  = reg_wdata_i[hfw_pkg::ROUTE_OVER_BIT]; // RULE_09
          s_next.route_under_fault_to_reset[ch] = reg_wdata_i[hfw_pkg::ROUTE_UNDER_BIT]; // RULE_10
        end
      end
    end

    // Reset request from routed debounced faults
    s_next.reset_req = |(over_flt & s_reg.route_over_fault_to_reset)  // RULE_09
                     | |(under_flt & s_reg.route_under_fault_to_reset); // RULE_10

    // Synchronous reset
    if (rst_i) begin
      s_next                            = '0;
      s_next.fast_over_limit            = {hfw_pkg::CH_NUM{hfw_pkg::LIMIT_RESET}};
      s_next.fast_under_limit           = {hfw_pkg::CH_NUM{hfw_pkg::LIMIT_RESET}};
      s_next.over_debounce_code         = {hfw_pkg::CH_NUM{hfw_pkg::CODE_RESET}};
      s_next.under_debounce_code        = {hfw_pkg::CH_NUM{hfw_pkg::CODE_RESET}};
      s_next.rdata                      = hfw_pkg::READ_ZERO;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    s_reg <= s_next;
  end

  // ==========================================================
  // Per-channel filters and limit scaling
  for (genvar ch = 0; ch < hfw_pkg::CH_NUM; ch++) begin : g_ch

    // Overvoltage comparator filter
    hfw_debounce u_over_deb (
      .sys_clk_i (sys_clk_i),
      .rst_i     (rst_i),
      .raw_i     (over_cmp_i[ch]),
      .code_i    (s_reg.over_debounce_code[ch]), // RULE_07
      .filt_o    (over_flt[ch])
    );

    // Undervoltage comparator filter
    hfw_debounce u_under_deb (
      .sys_clk_i (sys_clk_i),
      .rst_i     (rst_i),
      .raw_i     (under_cmp_i[ch]),
      .code_i    (s_reg.under_debounce_code[ch]), // RULE_08
      .filt_o    (under_flt[ch])
    );

    // Overvoltage limit in millivolts
    hfw_limit_scale u_over_scale (
      .sys_clk_i (sys_clk_i),
      .rst_i     (rst_i),
      .code_i    (s_reg.fast_over_limit[ch]),
      .scale_i   (range_multiplier_setting_i), // RULE_03
      .mv_o      (over_limit_mv_o[ch])
    );

    // Undervoltage limit in millivolts
    hfw_limit_scale u_under_scale (
      .sys_clk_i (sys_clk_i),
      .rst_i     (rst_i),
      .code_i    (s_reg.fast_under_limit[ch]),
      .scale_i   (range_multiplier_setting_i), // RULE_03
      .mv_o      (under_limit_mv_o[ch])
    );

  end

  // ==========================================================
  // Outputs
  assign reg_rdata_o             = s_reg.rdata;
  assign reg_rvalid_o            = s_reg.rvalid;
  assign fast_path_over_fault_o  = over_flt;
  assign fast_path_under_fault_o = under_flt;
  assign reset_output_o          = s_reg.reset_req; // RULE_11

endmodule // hfw_window_cfg

// File: bench/hfw_window_cfg_asserts.sv
module hfw_window_cfg_asserts (
  input wire logic                   sys_clk_i,
  input wire logic                   rst_i,
  input wire logic                   reg_rd_i,
  input wire logic [7:0]             reg_addr_i,
  input wire logic [7:0]             reg_rdata_o,
  input wire logic                   reg_rvalid_o,
  input wire hfw_pkg::hfw_scale_type range_multiplier_setting_i,
  input wire logic [1:0]             over_cmp_i,
  input wire logic [1:0]             under_cmp_i,
  input wire logic [1:0][12:0]       over_limit_mv_o,
  input wire logic [1:0]             fast_path_over_fault_o,
  input wire logic [1:0]             fast_path_under_fault_o,
  input wire logic                   reset_output_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // Helpers
  wire logic        quad = range_multiplier_setting_i == hfw_pkg::HFW_SCALE_QUAD;
  wire logic [12:0] mv2  = over_limit_mv_o[0];
  wire logic        anyf = |{fast_path_over_fault_o, fast_path_under_fault_o};
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // ==========================================================
  // Register port
  a_rd_answered: assert property (reg_rd_i |=> reg_rvalid_o)
    else $error("read not answered");
  a_rvalid_cause: assert property (reg_rvalid_o |-> $past(reg_rd_i))
    else $error("answer without read");
  a_rdata_idle: assert property (!reg_rvalid_o |-> reg_rdata_o == 8'h00)
    else $error("read data not zero when idle");
  a_route_rsvd: assert property (reg_rd_i && reg_addr_i[3:0] == 4'h5 |=>
    (reg_rdata_o & 8'he7) == 8'h00) else $error("reserved routing bits set");
  // ==========================================================
  // Scaling and filtering
  a_mv_unity: assert property (!$past(rst_i) && !$past(quad) |->
    mv2 inside {[200:1475]} && mv2 % 5 == 0) else $error("unity limit out of span");
  a_mv_quad: assert property (!$past(rst_i) && $past(quad) |->
    mv2 inside {[800:5900]} && mv2 % 20 == 0) else $error("fourfold limit out of span");
  a_over_stable: assert property ($rose(fast_path_over_fault_o[0]) |->
    $past(over_cmp_i[0], 1) && $past(over_cmp_i[0], 2) && $past(over_cmp_i[0], 3))
    else $error("fault raised before stable");
  a_under_restart: assert property (!under_cmp_i[1] |=>
    (!$rose(fast_path_under_fault_o[1])) [*3]) else $error("fault raised after glitch");
  a_reset_cause: assert property ($rose(reset_output_o) |-> $past(anyf))
    else $error("reset request without fault");
  // Main scenarios
  cover property ($rose(reset_output_o));
  cover property ($rose(fast_path_under_fault_o[1]));
  cover property (reg_rvalid_o && reg_rdata_o != 8'h00);
endmodule // hfw_window_cfg_asserts

bind hfw_window_cfg hfw_window_cfg_asserts u_hfw_window_cfg_asserts (.sys_clk_i, .rst_i,
  .reg_rd_i, .reg_addr_i, .reg_rdata_o, .reg_rvalid_o, .range_multiplier_setting_i,
  .over_cmp_i, .under_cmp_i, .over_limit_mv_o, .fast_path_over_fault_o,
  .fast_path_under_fault_o, .reset_output_o);

// File: bench/hfw_host_model.sv
module hfw_host_model (
  input  wire logic       sys_clk_i,
  output logic [7:0]      reg_addr_o,
  output logic [7:0]      reg_wdata_o,
  output logic            reg_wr_o,
  output logic            reg_rd_o,
  input  wire logic [7:0] reg_rdata_i,
  input  wire logic       reg_rvalid_i
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle bus at time zero
  initial begin
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
  end
  // One write; released lines show the inverse value
  task automatic wr(input logic [7:0] a, input logic [7:0] w);
    @(negedge sys_clk_i);
    reg_addr_o = a;
    reg_wdata_o = w;
    reg_wr_o = 1'b1;
    @(negedge sys_clk_i);
    reg_wr_o = 1'b0;
    reg_addr_o = ~a;
    reg_wdata_o = ~w;
  endtask
  // One read; answer taken the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] q, output logic v);
    @(negedge sys_clk_i);
    reg_addr_o = a;
    reg_rd_o = 1'b1;
    @(negedge sys_clk_i);
    reg_rd_o = 1'b0;
    reg_addr_o = ~a;
    q = reg_rdata_i;
    v = reg_rvalid_i;
  endtask
endmodule // hfw_host_model

// File: bench/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic                   sys_clk_i, rst_i, reg_wr_i, reg_rd_i, reg_rvalid_o, reset_output_o, v;
  logic [7:0]             reg_addr_i, reg_wdata_i, reg_rdata_o, d;
  logic [1:0]             ocmp, ucmp, ofl, ufl;
  logic [1:0][12:0]       omv, umv;
  logic [15:0]            r;
  hfw_pkg::hfw_scale_type rng;
  int                     num_errors, n_compared, n, ko, ku, w;
  int                     mdl [8];
  logic [7:0]             addrs [8] = '{8'h30, 8'h31, 8'h34, 8'h35, 8'h40, 8'h41, 8'h44, 8'h45};
  // ==========================================================
  // Design, host and clock
  hfw_window_cfg u_hfw_window_cfg (.sys_clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
    .reg_rd_i, .reg_rdata_o, .reg_rvalid_o, .range_multiplier_setting_i(rng),
    .over_cmp_i(ocmp), .under_cmp_i(ucmp), .over_limit_mv_o(omv), .under_limit_mv_o(umv),
    .fast_path_over_fault_o(ofl), .fast_path_under_fault_o(ufl), .reset_output_o);
  hfw_host_model u_hfw_host_model (.sys_clk_i, .reg_addr_o(reg_addr_i),
    .reg_wdata_o(reg_wdata_i), .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i),
    .reg_rdata_i(reg_rdata_o), .reg_rvalid_i(reg_rvalid_o));
  initial begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end
  // ==========================================================
  // Checking helpers
  task automatic chk(input logic [12:0] seen, input logic [12:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    if (num_errors == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  function automatic int mvexp(input int code);
    return (rng == hfw_pkg::HFW_SCALE_QUAD) ? 800 + 20 * code : 200 + 5 * code;
  endfunction
  // Read every register plus one unmapped address
  task automatic rdall;
    for (int i = 0; i < 8; i++) begin
      u_hfw_host_model.rd(addrs[i], d, v);
      chk({4'h0, v, d}, 13'(256 + mdl[i]));
    end
    u_hfw_host_model.rd(8'h32, d, v);
    chk({4'h0, v, d}, 13'h100);
  endtask
  task automatic mvchk;
    for (int c = 0; c < 2; c++) begin
      chk(omv[c], 13'(mvexp(mdl[c * 4 + 1])));
      chk(umv[c], 13'(mvexp(mdl[c * 4])));
    end
  endtask
  // Drive comparators to a level and count cycles until both faults follow
  task automatic cnt(input logic l);
    ocmp = {1'b0, l};
    ucmp = {l, 1'b0};
    ko = 0;
    ku = 0;
    for (int k = 1; k <= 3000 && !(ofl[0] == l && ufl[1] == l); k++) begin
      @(negedge sys_clk_i);
      if (ofl[0] == l && ko == 0) ko = k;
      if (ufl[1] == l && ku == 0) ku = k;
    end
    chk(13'(ko), 13'(n));
    chk(13'(ku), 13'(n));
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    num_errors = 0;
    n_compared = 0;
    rst_i = 1'b1;
    rng = hfw_pkg::HFW_SCALE_UNITY;
    ocmp = 2'b00;
    ucmp = 2'b00;
    mdl = '{default: 0};
    w = $urandom(32'hc60d);
    repeat (2) @(negedge sys_clk_i);
    rst_i = 1'b0;
    rdall;
    // Boundary codes, then random contents, in both ranges
    for (int p = 0; p < 4; p++) begin
      rng = hfw_pkg::hfw_scale_type'(p[0]);
      for (int i = 0; i < 8; i++) begin
        w = (p < 2) ? (p == 0 ? 255 : 0) : $urandom_range(255);
        mdl[i] = w & ((i % 4 == 3) ? 8'h18 : 8'hff);
        u_hfw_host_model.wr(addrs[i], 8'(w));
      end
      u_hfw_host_model.wr(8'h33, 8'h5a);
      rdall;
      mvchk;
      rng = hfw_pkg::hfw_scale_type'(~p[0]);
      repeat (2) @(negedge sys_clk_i);
      mvchk;
    end
    // Debounce codes 0 to 11, glitch first, then assert and release
    for (int c = 0; c < 12; c++) begin
      n = ((100 << (c > 10 ? 10 : c)) + 39) / 40;
      u_hfw_host_model.wr(8'h34, {c[3:0], ~c[3:0]});
      u_hfw_host_model.wr(8'h44, {~c[3:0], c[3:0]});
      ocmp = 2'b01;
      ucmp = 2'b10;
      repeat (n - 1) @(negedge sys_clk_i);
      chk(13'({ofl[0], ufl[1]}), 13'h0000);
      ocmp = 2'b00;
      ucmp = 2'b00;
      repeat (2) @(negedge sys_clk_i);
      chk(13'(ofl[0]), 13'h0000);
      chk(13'(ufl[1]), 13'h0000);
      cnt(1'b1);
      cnt(1'b0);
    end
    u_hfw_host_model.wr(8'h34, 8'h00);
    u_hfw_host_model.wr(8'h44, 8'h00);
    // Random faults against random routing, reserved bits written too
    for (int t = 0; t < 10; t++) begin
      r = 16'($urandom);
      ocmp = r[1:0];
      ucmp = r[3:2];
      u_hfw_host_model.wr(8'h35, {r[15:13], r[4], r[5], r[10:8]});
      u_hfw_host_model.wr(8'h45, {r[12:10], r[6], r[7], r[15:13]});
      repeat (4) @(negedge sys_clk_i);
      chk(13'({ofl, ufl}), 13'({r[1:0], r[3:2]}));
      chk(13'(reset_output_o), 13'(|(r[3:0] & {r[7], r[5], r[6], r[4]})));
      u_hfw_host_model.rd(8'h35, d, v);
      chk({4'h0, v, d}, 13'({1'b1, 3'b000, r[4], r[5], 3'b000}));
    end
    end_of_test;
  end
  // Watchdog
  initial begin
    repeat (40000) @(posedge sys_clk_i);
    num_errors++;
    end_of_test;
  end
endmodule // tb_top
